// ---- adcs_defs.svh ----
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// How it works
// - Starts are spaced so throughput never exceeds 100 ksps.
// - SAR clock is system clock divided by divider field plus one.
// - A conversion starts on software busy write, timer overflow or pin.
// - Busy stays high for the whole conversion, low when it ends.
// - Busy falling sets the done flag and the interrupt status bit.
// - Result lands in high and low registers, left or right aligned.
// - Normal tracking mode tracks the input whenever idle.
// - Low-power tracking adds three SAR clocks of tracking first, except on pin start.
// - Low-power with pin start tracks while pin low, converts on rise.
// - Tracking stops while the chip is asleep.
// - Results are ten bits wide.
// - Codes clamp at full scale or zero, never wrap.
// - Amplifier gain code steps gain upward through the gain table.

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADCS_A_CTRL 8'h00
`define ADCS_A_CFG 8'h04
`define ADCS_A_RESH 8'h08
`define ADCS_A_RESL 8'h0c
`define ADCS_A_HVA 8'h10
`define ADCS_A_ISTAT 8'h14
`define ADCS_A_ICLR 8'h18
`define ADCS_A_IEN 8'h1c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ADCS_B_TSEL 6
`define ADCS_B_DONE 5
`define ADCS_B_BUSY 4
`define ADCS_B_LJST 0
`define ADCS_B_HVEN 7
`define ADCS_R_CTRL 8'h00
`define ADCS_R_CFG 8'hf8
`define ADCS_R_HVA 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCS_CLK_HZ 20000000
`define ADCS_MAX_SPS 100000
`define ADCS_MIN_GAP (`ADCS_CLK_HZ / `ADCS_MAX_SPS)
`define ADCS_TRACK_TICKS 3
`define ADCS_RES_BITS 10
`endif

// ---- adcs_far_model.sv ----
`timescale 1ns/10ps
// ------
// Analog side: track-and-hold and comparator
// ------
module adcs_far_model
(
   input wire logic clk,
   input wire logic track_en,
   input wire logic [9:0] dac_code,
   input wire logic signed [15:0] level,
   output logic cmp_in
);
   logic signed [15:0] held_reg;

   // Sample only while tracked, so a late level change is missed
   always_ff @(posedge clk)
   begin
      if (track_en)
         held_reg <= level;
      // Levels past the rails still compare, clamping is the device's job
      cmp_in <= held_reg >= $signed({6'h00, dac_code});
   end
endmodule

// ---- adcs_pkg.sv ----
package adcs_pkg;
   typedef enum logic [1:0] {
      ADCS_IDLE = 2'b00,
      ADCS_TRACK = 2'b01,
      ADCS_CONV = 2'b10
   } adcs_state_t;
   typedef enum logic [1:0] {
      ADCS_SM_SW = 2'b00,
      ADCS_SM_T3 = 2'b01,
      ADCS_SM_EXT = 2'b10,
      ADCS_SM_T2 = 2'b11
   } adcs_smode_t;
endpackage

// ---- adcs_sequencer.sv ----
`timescale 1ns/10ps
`include "adcs_defs.svh"
module adcs_sequencer
   import adcs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic timer3_ovf,
   input wire logic timer2_ovf,
   input wire logic ext_convert_start,
   input wire logic cmp_in,
   input wire logic sleep_req,
   output logic track_en,
   output logic [9:0] dac_code,
   output logic hv_amp_enable,
   output logic [3:0] hv_amp_gain_code,
   output logic irq
);
   localparam logic [7:0] MIN_GAP = 8'(`ADCS_MIN_GAP);
   localparam logic [1:0] TRK_LAST = 2'(`ADCS_TRACK_TICKS - 1);
   localparam logic [9:0] MSB = 10'h200;

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic ext_m_reg, ext_s_reg, ext_d_reg, cmp_m_reg, cmp_s_reg;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         ext_m_reg <= 1'b0;
         ext_s_reg <= 1'b0;
         ext_d_reg <= 1'b0;
         cmp_m_reg <= 1'b0;
         cmp_s_reg <= 1'b0;
      end
      else
      begin
         ext_m_reg <= ext_convert_start;
         ext_s_reg <= ext_m_reg;
         ext_d_reg <= ext_s_reg;
         cmp_m_reg <= cmp_in;
         cmp_s_reg <= cmp_m_reg;
      end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
   logic [1:0] br_reg, br_next, rr_reg, rr_next;
   logic [7:0] aa_reg, aa_next, wd_reg, wd_next;
   logic ws_reg, ws_next, arr_reg, arr_next, rv_reg, rv_next;
   logic [31:0] rd_reg, rd_next;
   logic wr_do, wr_en;
   logic [7:0] rsel;

   logic tsel_reg, done_reg, busy_reg, ljst_reg;
   adcs_smode_t smode_reg;
   logic [7:0] cfg_reg, res_hi_reg, res_lo_reg;
   logic hven_reg, ist_reg, ien_reg;
   logic [3:0] gain_reg;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a[7:5] == 3'b000);
   endfunction

   always_comb
   begin
      awr_next = awr_reg;
      wr_next = wr_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      aa_next = aa_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      arr_next = arr_reg;
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      rsel = 8'h00;
      // Address and data held until both are in, either order
      if (awr_reg && s_awvalid)
      begin
         awr_next = 1'b0;
         aa_next = s_awaddr;
      end
      if (wr_reg && s_wvalid)
      begin
         wr_next = 1'b0;
         wd_next = s_wdata[7:0];
         ws_next = s_wstrb[0];
      end
      wr_do = !awr_reg && !wr_reg && !bv_reg;
      wr_en = wr_do && ws_reg && mapped(aa_reg);
      if (wr_do)
      begin
         bv_next = 1'b1;
         br_next = mapped(aa_reg) ? 2'b00 : 2'b10;
      end
      if (bv_reg && s_bready)
      begin
         bv_next = 1'b0;
         awr_next = 1'b1;
         wr_next = 1'b1;
      end
      if (arr_reg && s_arvalid)
      begin
         arr_next = 1'b0;
         rv_next = 1'b1;
         rr_next = mapped(s_araddr) ? 2'b00 : 2'b10;
         unique case (s_araddr)
            `ADCS_A_CTRL: rsel = {1'b0, tsel_reg, done_reg, busy_reg,
               smode_reg, 1'b0, ljst_reg};
            `ADCS_A_CFG: rsel = cfg_reg;
            `ADCS_A_RESH: rsel = res_hi_reg;
            `ADCS_A_RESL: rsel = res_lo_reg;
            `ADCS_A_HVA: rsel = {hven_reg, 3'b000, gain_reg};
            `ADCS_A_ISTAT: rsel = {7'h00, ist_reg};
            `ADCS_A_IEN: rsel = {7'h00, ien_reg};
            default: rsel = 8'h00;
         endcase
         rd_next = {24'h000000, rsel};
      end
      if (rv_reg && s_rready)
      begin
         rv_next = 1'b0;
         arr_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         awr_reg <= 1'b1;
         wr_reg <= 1'b1;
         bv_reg <= 1'b0;
         br_reg <= 2'b00;
         aa_reg <= 8'h00;
         wd_reg <= 8'h00;
         ws_reg <= 1'b0;
         arr_reg <= 1'b1;
         rv_reg <= 1'b0;
         rd_reg <= 32'h00000000;
         rr_reg <= 2'b00;
      end
      else
      begin
         awr_reg <= awr_next;
         wr_reg <= wr_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         aa_reg <= aa_next;
         wd_reg <= wd_next;
         ws_reg <= ws_next;
         arr_reg <= arr_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
      end

   assign s_awready = awr_reg;
   assign s_wready = wr_reg;
   assign s_bvalid = bv_reg;
   assign s_bresp = br_reg;
   assign s_arready = arr_reg;
   assign s_rvalid = rv_reg;
   assign s_rdata = rd_reg;
   assign s_rresp = rr_reg;

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   adcs_state_t st_reg, st_next;
   adcs_smode_t smode_next;
   logic tsel_next, done_next, busy_next, ljst_next, hven_next;
   logic ist_next, ien_next, irq_reg, irq_next, trk_reg, trk_next;
   logic [7:0] cfg_next, res_hi_next, res_lo_next, gap_reg, gap_next;
   logic [3:0] gain_next;
   logic [4:0] div_reg, div_next;
   logic [1:0] tc_reg, tc_next;
   logic [9:0] mask_reg, mask_next, code_reg, code_next;
   logic [9:0] dac_reg, dac_next, code_up;
   logic trig, start, tick, w_ctrl;

   always_comb
   begin
      st_next = st_reg;
      smode_next = smode_reg;
      tsel_next = tsel_reg;
      done_next = done_reg;
      ljst_next = ljst_reg;
      cfg_next = cfg_reg;
      hven_next = hven_reg;
      gain_next = gain_reg;
      ien_next = ien_reg;
      ist_next = ist_reg;
      res_hi_next = res_hi_reg;
      res_lo_next = res_lo_reg;
      tc_next = tc_reg;
      mask_next = mask_reg;
      code_next = code_reg;
      dac_next = dac_reg;
      w_ctrl = wr_en && (aa_reg == `ADCS_A_CTRL);
      if (w_ctrl)
      begin
         tsel_next = wd_reg[`ADCS_B_TSEL];
         done_next = wd_reg[`ADCS_B_DONE];
         smode_next = adcs_smode_t'(wd_reg[3:2]);
         ljst_next = wd_reg[`ADCS_B_LJST];
      end
      if (wr_en && (aa_reg == `ADCS_A_CFG))
         cfg_next = wd_reg;
      if (wr_en && (aa_reg == `ADCS_A_HVA))
      begin
         hven_next = wd_reg[`ADCS_B_HVEN];
         gain_next = wd_reg[3:0];
      end
      if (wr_en && (aa_reg == `ADCS_A_IEN))
         ien_next = wd_reg[0];
      if (wr_en && (aa_reg == `ADCS_A_ICLR) && wd_reg[0])
         ist_next = 1'b0;
      unique case (smode_reg)
         ADCS_SM_SW: trig = w_ctrl && wd_reg[`ADCS_B_BUSY];
         ADCS_SM_T3: trig = timer3_ovf;
         ADCS_SM_EXT: trig = ext_s_reg && !ext_d_reg;
         ADCS_SM_T2: trig = timer2_ovf;
      endcase
      // Starts while busy or too soon are dropped, not queued
      start = trig && (st_reg == ADCS_IDLE) && (gap_reg == 8'h00);
      gap_next = start ? MIN_GAP - 8'h01 :
         ((gap_reg != 8'h00) ? gap_reg - 8'h01 : gap_reg);
      tick = (div_reg == cfg_reg[7:3]);
      div_next = (st_reg == ADCS_IDLE || tick) ? 5'h00 : div_reg + 5'h01;
      code_up = cmp_s_reg ? dac_reg : code_reg;
      unique case (st_reg)
         ADCS_IDLE:
            if (start)
            begin
               tc_next = 2'b00;
               mask_next = MSB;
               code_next = 10'h000;
               dac_next = MSB;
               // Pin start in low-power mode has already tracked
               if (tsel_reg && smode_reg != ADCS_SM_EXT)
                  st_next = ADCS_TRACK;
               else
                  st_next = ADCS_CONV;
            end
         ADCS_TRACK:
            if (tick)
            begin
               tc_next = tc_reg + 2'b01;
               if (tc_reg == TRK_LAST)
                  st_next = ADCS_CONV;
            end
         ADCS_CONV:
            if (tick)
            begin
               // Trial bit kept only when input is at or above it; clamps
               code_next = code_up;
               mask_next = mask_reg >> 1;
               dac_next = code_up | (mask_reg >> 1);
               if (mask_reg[0])
               begin
                  st_next = ADCS_IDLE;
                  done_next = 1'b1;
                  ist_next = 1'b1;
                  dac_next = 10'h000;
                  if (ljst_reg)
                  begin
                     res_hi_next = code_up[9:2];
                     res_lo_next = {code_up[1:0], 6'h00};
                  end
                  else
                  begin
                     res_hi_next = {6'h00, code_up[9:8]};
                     res_lo_next = code_up[7:0];
                  end
               end
            end
         default: st_next = ADCS_IDLE;
      endcase
      busy_next = (st_next != ADCS_IDLE);
      irq_next = ist_next && ien_next;
      if (sleep_req)
         trk_next = 1'b0;
      else if (st_reg == ADCS_IDLE)
         trk_next = !tsel_reg || (smode_reg == ADCS_SM_EXT && !ext_s_reg);
      else
         trk_next = (st_reg == ADCS_TRACK);
   end

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         st_reg <= ADCS_IDLE;
         smode_reg <= ADCS_SM_SW;
         tsel_reg <= 1'b0;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
         ljst_reg <= 1'b0;
         cfg_reg <= `ADCS_R_CFG;
         hven_reg <= 1'b0;
         gain_reg <= 4'h0;
         ien_reg <= 1'b0;
         ist_reg <= 1'b0;
         irq_reg <= 1'b0;
         res_hi_reg <= 8'h00;
         res_lo_reg <= 8'h00;
         gap_reg <= 8'h00;
         div_reg <= 5'h00;
         tc_reg <= 2'b00;
         mask_reg <= 10'h000;
         code_reg <= 10'h000;
         dac_reg <= 10'h000;
         trk_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         smode_reg <= smode_next;
         tsel_reg <= tsel_next;
         done_reg <= done_next;
         busy_reg <= busy_next;
         ljst_reg <= ljst_next;
         cfg_reg <= cfg_next;
         hven_reg <= hven_next;
         gain_reg <= gain_next;
         ien_reg <= ien_next;
         ist_reg <= ist_next;
         irq_reg <= irq_next;
         res_hi_reg <= res_hi_next;
         res_lo_reg <= res_lo_next;
         gap_reg <= gap_next;
         div_reg <= div_next;
         tc_reg <= tc_next;
         mask_reg <= mask_next;
         code_reg <= code_next;
         dac_reg <= dac_next;
         trk_reg <= trk_next;
      end

   assign track_en = trk_reg;
   assign dac_code = dac_reg;
   assign hv_amp_enable = hven_reg;
   assign hv_amp_gain_code = gain_reg;
   assign irq = irq_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [7:0] since_reg;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         since_reg <= 8'hff;
      else
         since_reg <= start ? 8'h00 :
            ((since_reg == 8'hff) ? since_reg : since_reg + 8'h01);

   start_spacing_a: assert property (@(posedge clk) disable iff (!arst_n)
      start |-> since_reg >= MIN_GAP - 8'h01)
      else $error("conversion started too soon");
   sar_divide_a: assert property (@(posedge clk) disable iff (!arst_n)
      (st_reg == ADCS_CONV && tick && cfg_reg[7:3] != 5'h00)
      |=> !tick)
      else $error("sar tick not divided");
   timer_start_a: assert property (@(posedge clk) disable iff (!arst_n)
      (smode_reg == ADCS_SM_T3 && timer3_ovf && st_reg == ADCS_IDLE
      && gap_reg == 8'h00) |=> busy_reg)
      else $error("timer 3 start missed");
   busy_span_a: assert property (@(posedge clk) disable iff (!arst_n)
      busy_reg == (st_reg != ADCS_IDLE))
      else $error("busy not matching conversion");
   done_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(busy_reg) |-> done_reg && ist_reg)
      else $error("done not set at end");
   left_align_a: assert property (@(posedge clk) disable iff (!arst_n)
      ($fell(busy_reg) && $past(ljst_reg)) |-> res_lo_reg[5:0] == 6'h00)
      else $error("left result misaligned");
   cont_track_a: assert property (@(posedge clk) disable iff (!arst_n)
      (st_reg == ADCS_IDLE && !tsel_reg && !sleep_req) |=> track_en)
      else $error("idle input not tracking");
   track_len_a: assert property (@(posedge clk) disable iff (!arst_n)
      (st_reg == ADCS_TRACK && tick && tc_reg == TRK_LAST)
      |=> st_reg == ADCS_CONV && dac_code == MSB)
      else $error("tracking interval wrong");
   pin_track_a: assert property (@(posedge clk) disable iff (!arst_n)
      (st_reg == ADCS_IDLE && tsel_reg && smode_reg == ADCS_SM_EXT
      && !sleep_req) |=> track_en == !$past(ext_s_reg))
      else $error("pin tracking wrong");
   sleep_track_a: assert property (@(posedge clk) disable iff (!arst_n)
      sleep_req |=> !track_en)
      else $error("tracking while asleep");
endmodule

// ---- test_adcs_sequencer.sv ----
`timescale 1ns/10ps
`include "adcs_defs.svh"
module test_adcs_sequencer
   import adcs_pkg::*;
;
   logic clk = 0;
   logic arst_n = 0;
   logic [7:0] s_awaddr = 0, s_araddr = 0, rd;
   logic [31:0] s_wdata = 0, s_rdata, seed = 32'hb4cc;
   logic [3:0] s_wstrb = 0, hv_amp_gain_code;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
   logic s_rready = 0, timer3_ovf = 0, timer2_ovf = 0;
   logic ext_convert_start = 0, sleep_req = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cmp_in;
   logic track_en, hv_amp_enable, irq;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic [9:0] dac_code;
   logic signed [15:0] level = 0;
   logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1c, 8'h18};
   logic [7:0] rv[6] = '{8'h00, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
   logic signed [15:0] corner[4] = '{-16'sd20, 16'sd0, 16'sd1023, 16'sd1500};
   int errors = 0, checks_done = 0, conv_cnt = 0, track_cnt = 0, div = 3;

   always #25 clk = ~clk;

   adcs_sequencer dut (.clk, .arst_n, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .timer3_ovf, .timer2_ovf, .ext_convert_start,
      .cmp_in, .sleep_req, .track_en, .dac_code, .hv_amp_enable,
      .hv_amp_gain_code, .irq);

   adcs_far_model far (.clk, .track_en, .dac_code, .level, .cmp_in);

   // ------
   // Helpers
   // ------
   always @(negedge clk)
   begin
      conv_cnt = conv_cnt + int'(dac_code != 10'h000);
      track_cnt = track_cnt + int'(track_en);
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Returns the high and low result bytes together
   function automatic logic [15:0] expect_res(logic signed [15:0] lv,
      logic lj);
      logic [9:0] c;
      c = lv < 0 ? 10'h000 : (lv > 1023 ? 10'h3ff : lv[9:0]);
      return lj ? {c, 6'h00} : {6'h00, c};
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cmp_range(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("unexpected at %0t: count %0d", $time, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w, b;
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= {24'h000000, d};
      s_wstrb <= 4'h1;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      b = 0;
      while (!b)
      begin
         @(negedge clk);
         aw = s_awvalid & s_awready;
         w = s_wvalid & s_wready;
         b = s_bvalid === 1'b1;
         rsp = s_bresp;
         @(posedge clk);
         if (aw)
            s_awvalid <= 1'b0;
         if (w)
            s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      logic ar, r;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      r = 0;
      while (!r)
      begin
         @(negedge clk);
         ar = s_arvalid & s_arready;
         r = s_rvalid === 1'b1;
         rd = s_rdata[7:0];
         rsp = s_rresp;
         @(posedge clk);
         if (ar)
            s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
   endtask

   task automatic pulse(input logic t3, input logic t2);
      timer3_ovf <= t3;
      timer2_ovf <= t2;
      @(posedge clk);
      timer3_ovf <= 1'b0;
      timer2_ovf <= 1'b0;
   endtask

   task automatic convert(input logic [1:0] m, input logic ts,
      input logic signed [15:0] lv);
      logic lj;
      logic [15:0] e;
      int n;
      lj = rnd() % 2;
      level <= lv;
      wr(`ADCS_A_CTRL, {1'b0, ts, 2'b00, m, 1'b0, lj});
      repeat (10) @(posedge clk);
      conv_cnt = 0;
      track_cnt = 0;
      if (m == ADCS_SM_SW)
         wr(`ADCS_A_CTRL, {1'b0, ts, 2'b01, m, 1'b0, lj});
      if (m == ADCS_SM_EXT)
      begin
         ext_convert_start <= 1'b0;
         repeat (20) @(posedge clk);
         cmp(16'(track_en), 16'h1);
         ext_convert_start <= 1'b1;
      end
      pulse(m == ADCS_SM_T3, m == ADCS_SM_T2);
      repeat (4) @(posedge clk);
      rd_reg(`ADCS_A_CTRL);
      cmp(16'(rd[4]), 16'h1);
      n = 0;
      do
      begin
         rd_reg(`ADCS_A_CTRL);
         n++;
      end
      while (rd[5] !== 1'b1 && n < 100);
      cmp(16'(rd[5:4]), 16'h2);
      if (!ts || m == ADCS_SM_EXT)
         cmp_range(conv_cnt, 9 * (div + 1), 10 * (div + 1) + 2);
      else
         cmp_range(track_cnt, 2 * (div + 1), 3 * (div + 1) + 2);
      e = expect_res(lv, lj);
      rd_reg(`ADCS_A_RESH);
      cmp(16'(rd), 16'(e[15:8]));
      rd_reg(`ADCS_A_RESL);
      cmp(16'(rd), 16'(e[7:0]));
      wr(`ADCS_A_CTRL, {1'b0, ts, 2'b00, m, 1'b0, lj});
      repeat (200) @(posedge clk);
   endtask

   // ------
   // Main sequence
   // ------
   initial
   begin
      logic [7:0] v;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(ra[i]);
         cmp(16'(rd), 16'(rv[i]));
      end
      rd_reg(8'h24);
      cmp(16'(rsp), 16'h2);
      wr(8'h24, 8'hff);
      cmp(16'(rsp), 16'h2);
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         wr(`ADCS_A_HVA, v);
         repeat (2) @(posedge clk);
         cmp({hv_amp_enable, hv_amp_gain_code}, {v[7], v[3:0]});
         rd_reg(`ADCS_A_HVA);
         cmp(16'(rd), 16'(v & 8'h8f));
      end
      wr(`ADCS_A_CFG, 8'h18);
      for (int m = 0; m < 4; m++)
         convert(2'(m), 1'b0, corner[m]);
      for (int m = 0; m < 4; m++)
         convert(2'(m), 1'b1, 16'(rnd() % 1024));
      div = 7;
      wr(`ADCS_A_CFG, 8'h38);
      convert(ADCS_SM_SW, 1'b0, 16'(rnd() % 1024));
      div = 3;
      wr(`ADCS_A_CFG, 8'h18);
      wr(`ADCS_A_ICLR, 8'h01);
      wr(`ADCS_A_IEN, 8'h01);
      convert(ADCS_SM_T3, 1'b0, 16'(rnd() % 1024));
      cmp(16'(irq), 16'h1);
      wr(`ADCS_A_ICLR, 8'h01);
      repeat (2) @(posedge clk);
      cmp(16'(irq), 16'h0);
      wr(`ADCS_A_IEN, 8'h00);
      convert(ADCS_SM_T2, 1'b0, 16'(rnd() % 1024));
      rd_reg(`ADCS_A_ISTAT);
      cmp({15'h0000, irq}, {15'h0000, 1'b0});
      cmp(16'(rd), 16'h1);
      wr(`ADCS_A_ICLR, 8'h01);
      // Wrong timer, then a start too soon after the last one
      wr(`ADCS_A_CTRL, 8'h04);
      pulse(1'b0, 1'b1);
      repeat (20) @(posedge clk);
      rd_reg(`ADCS_A_CTRL);
      cmp(16'(rd[5:4]), 16'h0);
      pulse(1'b1, 1'b0);
      repeat (120) @(posedge clk);
      wr(`ADCS_A_CTRL, 8'h04);
      pulse(1'b1, 1'b0);
      repeat (60) @(posedge clk);
      rd_reg(`ADCS_A_CTRL);
      cmp(16'(rd[5:4]), 16'h0);
      repeat (200) @(posedge clk);
      pulse(1'b1, 1'b0);
      repeat (80) @(posedge clk);
      rd_reg(`ADCS_A_CTRL);
      cmp(16'(rd[5:4]), 16'h2);
      sleep_req <= 1'b1;
      repeat (3) @(posedge clk);
      cmp(16'(track_en), 16'h0);
      sleep_req <= 1'b0;
      repeat (3) @(posedge clk);
      cmp(16'(track_en), 16'h1);
      conclude();
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule
